// [hdl/mecs_pkg.sv]
// Package for the MAC error statistics counter block
package mecs_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Counter register byte offsets
    localparam logic [7:0] OFS_EXCESS_COLLISION   = 8'h00;
    localparam logic [7:0] OFS_TX_UNDERRUN        = 8'h04;
    localparam logic [7:0] OFS_CARRIER_SENSE_ERR  = 8'h08;
    localparam logic [7:0] OFS_RX_NO_BUFFER       = 8'h0c;
    localparam logic [7:0] OFS_RX_DMA_OVERRUN     = 8'h10;
    localparam logic [7:0] OFS_RX_SYMBOL_ERROR    = 8'h14;
    localparam logic [7:0] OFS_RX_OVERSIZE_CLEAN  = 8'h18;
    localparam logic [7:0] OFS_RX_OVERSIZE_BAD    = 8'h1c;
    localparam logic [7:0] OFS_RX_RUNT_CLEAN      = 8'h20;
    localparam logic [7:0] OFS_HEARTBEAT_MISSING  = 8'h24;
    localparam logic [7:0] OFS_LENGTH_MISMATCH    = 8'h28;
    // Control register standing in for the network control/config bits
    localparam logic [7:0] OFS_CTRL               = 8'h2c;

    // Control register bit positions
    localparam int CTRL_RX_EN_BIT      = 3;
    localparam int CTRL_STAT_WR_EN_BIT = 7;
    localparam int CTRL_FULL_DUPLEX_BIT = 9;
    localparam int CTRL_LONG_FRAME_BIT = 8;
    localparam int CTRL_LEN_CHECK_BIT  = 16;
    localparam logic [31:0] CTRL_MASK  = 32'h0001_0388;

    localparam int NUM_CNT = 11;
    localparam int IDX_EXCESS_COLLISION_FIELD = 0;
    localparam int IDX_TX_UNDERRUN_FIELD  = 1;
    localparam int IDX_CSE   = 2;
    localparam int IDX_RRE   = 3;
    localparam int IDX_RX_DMA_OVERRUN_FIELD  = 4;
    localparam int IDX_RSE   = 5;
    localparam int IDX_EXL   = 6;
    localparam int IDX_RJB   = 7;
    localparam int IDX_USF   = 8;
    localparam int IDX_SQE   = 9;
    localparam int IDX_LENGTH_MISMATCH_FIELD  = 10;

    localparam int CNT8_W  = 8;
    localparam int CNT16_W = 16;

    // Frame length limits in bytes
    localparam logic [15:0] LEN_MIN        = 16'h0040;
    localparam logic [15:0] LEN_MAX_STD    = 16'h05ee;
    localparam logic [15:0] LEN_MAX_LONG   = 16'h0600;
    localparam logic [15:0] TYPE_THRESHOLD = 16'h0600;

    typedef struct packed {
        logic excess_collision;   // 16 collisions, frame abandoned
        logic underrun;           // transmit DMA ran dry
        logic carrier_sense_lost; // carrier never seen or dropped
        logic collision_seen;     // any collision during frame
        logic heartbeat_missing;  // no collision indication in 96 bit times
    } mecs_tx_evt_t;

    typedef struct packed {
        logic        no_buffer;    // address matched, no buffer
        logic        dma_overrun;  // address recognized, DMA overrun
        logic        symbol_error; // phy receive error seen
        logic        crc_error;    // bad FCS
        logic        align_error;  // not integral bytes
        logic [15:0] length;       // measured byte length
        logic [15:0] len_type;     // length/type field value
    } mecs_rx_evt_t;

endpackage : mecs_pkg

// [hdl/mecs_counters.sv]
// MAC error statistics counters with register port
// What this block does
// - Eight-bit count of frames abandoned after sixteen collisions.
// - Eight-bit count of frames dropped by transmit DMA underrun.
// - An underrun frame bumps no other counter.
// - Eight-bit count of clean transmitted frames losing or missing carrier sense.
// - Carrier sense error counter advances only in half duplex.
// - Carrier sense error affects nothing but its own counter.
// - Sixteen-bit count of matched frames lost for lack of buffer.
// - Eight-bit count of recognized frames lost to receive DMA overrun.
// - Eight-bit count of frames received with phy receive error.
// - Symbol error in overlong frame also counts as jabber.
// - Eight-bit count of clean overlong frames, limit 1518 or 1536.
// - Eight-bit count of overlong frames with CRC, alignment or symbol error.
// - Eight-bit count of clean frames shorter than 64 bytes.
// - Half duplex: count frames lacking collision indication within 96 bit times.
// - Eight-bit count of frames shorter than their length field.
// - Length mismatch check only with configuration bit 16 set.
// - Type values from 0x0600 and overlong frames never count as mismatch.
// - Counters clear on read and saturate at all ones.
// - Receive counters advance only with receive enable set.
// - Counter writes take effect only with control bit 7 set.
//
// Our own choices: the register addresses and the address-and-strobe port.
module mecs_counters (
    input  wire logic                         core_clk,    // System clock
    input  wire logic                         rst,         // Async reset, active high
    input  wire logic [mecs_pkg::ADDR_W-1:0]  reg_addr,    // Register byte address
    input  wire logic [mecs_pkg::DATA_W-1:0]  reg_wdata,   // Write data
    input  wire logic                         reg_wr,      // Write strobe
    input  wire logic                         reg_rd,      // Read strobe
    output logic      [mecs_pkg::DATA_W-1:0]  reg_rdata,   // Read data, cycle after strobe
    input  wire logic                         tx_done,     // Transmit frame finished, one pulse
    input  wire mecs_pkg::mecs_tx_evt_t       tx_evt,      // Transmit outcome, valid with tx_done
    input  wire logic                         rx_done,     // Receive frame finished, one pulse
    input  wire mecs_pkg::mecs_rx_evt_t       rx_evt,      // Receive outcome, valid with rx_done
    output logic      [mecs_pkg::DATA_W-1:0]  ctrl_out     // Control register contents
);

    logic [mecs_pkg::DATA_W-1:0]  ctrl_word;
    logic [mecs_pkg::CNT16_W-1:0] cnt_r [mecs_pkg::NUM_CNT];
    logic [mecs_pkg::CNT16_W-1:0] cnt_nxt [mecs_pkg::NUM_CNT];
    logic [mecs_pkg::NUM_CNT-1:0] inc;
    logic [mecs_pkg::NUM_CNT-1:0] tx_inc;
    logic [mecs_pkg::NUM_CNT-1:0] rx_inc;
    logic [mecs_pkg::NUM_CNT-1:0] rd_hit;
    logic [mecs_pkg::NUM_CNT-1:0] wr_hit;
    logic [mecs_pkg::DATA_W-1:0]  rdata_nxt;
    logic                         rx_en;
    logic                         stat_wr_en;
    logic                         half_duplex;
    logic                         len_check;
    logic [15:0]                  max_len;
    logic                         rx_bad;
    logic                         rx_long;
    logic                         rx_short;
    logic                         rx_en_r;
    logic                         stat_wr_en_r;
    logic                         long_frame_r;
    logic                         full_duplex_r;
    logic                         len_check_r;
    logic                         ctrl_wr;

    // Counter width for each index
    function automatic int cnt_width(input int idx);
        cnt_width = (idx == mecs_pkg::IDX_RRE) ? mecs_pkg::CNT16_W : mecs_pkg::CNT8_W;
    endfunction : cnt_width

    // Byte offset of each counter register
    function automatic logic [7:0] cnt_offset(input int idx);
        case (idx)
            mecs_pkg::IDX_EXCESS_COLLISION_FIELD: cnt_offset = mecs_pkg::OFS_EXCESS_COLLISION;
            mecs_pkg::IDX_TX_UNDERRUN_FIELD:  cnt_offset = mecs_pkg::OFS_TX_UNDERRUN;
            mecs_pkg::IDX_CSE:   cnt_offset = mecs_pkg::OFS_CARRIER_SENSE_ERR;
            mecs_pkg::IDX_RRE:   cnt_offset = mecs_pkg::OFS_RX_NO_BUFFER;
            mecs_pkg::IDX_RX_DMA_OVERRUN_FIELD:  cnt_offset = mecs_pkg::OFS_RX_DMA_OVERRUN;
            mecs_pkg::IDX_RSE:   cnt_offset = mecs_pkg::OFS_RX_SYMBOL_ERROR;
            mecs_pkg::IDX_EXL:   cnt_offset = mecs_pkg::OFS_RX_OVERSIZE_CLEAN;
            mecs_pkg::IDX_RJB:   cnt_offset = mecs_pkg::OFS_RX_OVERSIZE_BAD;
            mecs_pkg::IDX_USF:   cnt_offset = mecs_pkg::OFS_RX_RUNT_CLEAN;
            mecs_pkg::IDX_SQE:   cnt_offset = mecs_pkg::OFS_HEARTBEAT_MISSING;
            default:             cnt_offset = mecs_pkg::OFS_LENGTH_MISMATCH;
        endcase
    endfunction : cnt_offset

    // All-ones value at a counter's width
    function automatic logic [15:0] cnt_max(input int idx);
        cnt_max = (cnt_width(idx) == mecs_pkg::CNT16_W) ? 16'hffff : 16'h00ff;
    endfunction : cnt_max

    // Next value of one counter: enabled write, clear on read, saturating count
    function automatic logic [15:0] cnt_step(
        input int          idx,   // Counter index
        input logic [15:0] cur,   // Present count
        input logic        bump,  // Event this cycle
        input logic        rd,    // Read of this counter
        input logic        wr,    // Enabled write of this counter
        input logic [15:0] wdata  // Write data
    );
        if (wr) begin
            cnt_step = wdata & cnt_max(idx);
        end else if (rd) begin
            cnt_step = bump ? 16'h0001 : 16'h0000;
        end else if (bump && cur != cnt_max(idx)) begin
            cnt_step = cur + 16'h0001;
        end else begin
            cnt_step = cur;
        end
    endfunction : cnt_step

    assign rx_en       = rx_en_r;
    assign stat_wr_en  = stat_wr_en_r;
    assign half_duplex = ~full_duplex_r;
    assign len_check   = len_check_r;
    assign ctrl_wr     = reg_wr && (reg_addr == mecs_pkg::OFS_CTRL);
    assign max_len     = long_frame_r ? mecs_pkg::LEN_MAX_LONG
                                      : mecs_pkg::LEN_MAX_STD;
    assign rx_bad   = rx_evt.crc_error | rx_evt.align_error | rx_evt.symbol_error;
    assign rx_long  = rx_evt.length > max_len;
    assign rx_short = rx_evt.length < mecs_pkg::LEN_MIN;

    // Transmit outcome decode
    always_comb begin
        tx_inc = '0;
        // Underrun frame touches only its own counter
        if (tx_done && tx_evt.underrun) begin
            tx_inc[mecs_pkg::IDX_TX_UNDERRUN_FIELD] = 1'b1;
        end else if (tx_done) begin
            tx_inc[mecs_pkg::IDX_EXCESS_COLLISION_FIELD] = tx_evt.excess_collision;
            tx_inc[mecs_pkg::IDX_CSE]   = tx_evt.carrier_sense_lost &&
                                          !tx_evt.collision_seen && half_duplex;
            tx_inc[mecs_pkg::IDX_SQE]   = tx_evt.heartbeat_missing && half_duplex;
        end
    end

    // Receive outcome decode
    always_comb begin
        rx_inc = '0;
        if (rx_done && rx_en) begin
            rx_inc[mecs_pkg::IDX_RRE]  = rx_evt.no_buffer;
            rx_inc[mecs_pkg::IDX_RX_DMA_OVERRUN_FIELD] = rx_evt.dma_overrun;
            rx_inc[mecs_pkg::IDX_RSE]  = rx_evt.symbol_error;
            rx_inc[mecs_pkg::IDX_EXL]  = rx_long && !rx_bad;
            rx_inc[mecs_pkg::IDX_RJB]  = rx_long && rx_bad;
            rx_inc[mecs_pkg::IDX_USF]  = rx_short && !rx_bad;
            rx_inc[mecs_pkg::IDX_LENGTH_MISMATCH_FIELD] = len_check && !rx_long &&
                                         rx_evt.len_type < mecs_pkg::TYPE_THRESHOLD &&
                                         rx_evt.length < rx_evt.len_type;
        end
    end

    assign inc = tx_inc | rx_inc;

    // Address decode per counter
    always_comb begin
        for (int i = 0; i < mecs_pkg::NUM_CNT; i++) begin
            rd_hit[i] = reg_rd && (reg_addr == cnt_offset(i));
            wr_hit[i] = reg_wr && (reg_addr == cnt_offset(i));
        end
    end

    // Next value of every counter
    always_comb begin
        for (int i = 0; i < mecs_pkg::NUM_CNT; i++) begin
            cnt_nxt[i] = cnt_step(i, cnt_r[i], inc[i], rd_hit[i], wr_hit[i] && stat_wr_en,
                                  reg_wdata[mecs_pkg::CNT16_W-1:0]);
        end
    end

    // Frames abandoned after sixteen collisions
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r[mecs_pkg::IDX_EXCESS_COLLISION_FIELD] <= '0;
        end else begin
            cnt_r[mecs_pkg::IDX_EXCESS_COLLISION_FIELD] <= cnt_nxt[mecs_pkg::IDX_EXCESS_COLLISION_FIELD];
        end
    end

    // Frames dropped by transmit underrun
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r[mecs_pkg::IDX_TX_UNDERRUN_FIELD] <= '0;
        end else begin
            cnt_r[mecs_pkg::IDX_TX_UNDERRUN_FIELD] <= cnt_nxt[mecs_pkg::IDX_TX_UNDERRUN_FIELD];
        end
    end

    // Carrier sense errors
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r[mecs_pkg::IDX_CSE] <= '0;
        end else begin
            cnt_r[mecs_pkg::IDX_CSE] <= cnt_nxt[mecs_pkg::IDX_CSE];
        end
    end

    // Frames lost for lack of buffer, sixteen bits
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r[mecs_pkg::IDX_RRE] <= '0;
        end else begin
            cnt_r[mecs_pkg::IDX_RRE] <= cnt_nxt[mecs_pkg::IDX_RRE];
        end
    end

    // Frames lost to receive overrun
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r[mecs_pkg::IDX_RX_DMA_OVERRUN_FIELD] <= '0;
        end else begin
            cnt_r[mecs_pkg::IDX_RX_DMA_OVERRUN_FIELD] <= cnt_nxt[mecs_pkg::IDX_RX_DMA_OVERRUN_FIELD];
        end
    end

    // Frames with receive symbol errors
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r[mecs_pkg::IDX_RSE] <= '0;
        end else begin
            cnt_r[mecs_pkg::IDX_RSE] <= cnt_nxt[mecs_pkg::IDX_RSE];
        end
    end

    // Clean overlong frames
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r[mecs_pkg::IDX_EXL] <= '0;
        end else begin
            cnt_r[mecs_pkg::IDX_EXL] <= cnt_nxt[mecs_pkg::IDX_EXL];
        end
    end

    // Damaged overlong frames
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r[mecs_pkg::IDX_RJB] <= '0;
        end else begin
            cnt_r[mecs_pkg::IDX_RJB] <= cnt_nxt[mecs_pkg::IDX_RJB];
        end
    end

    // Clean short frames
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r[mecs_pkg::IDX_USF] <= '0;
        end else begin
            cnt_r[mecs_pkg::IDX_USF] <= cnt_nxt[mecs_pkg::IDX_USF];
        end
    end

    // Frames lacking collision indication after transmit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r[mecs_pkg::IDX_SQE] <= '0;
        end else begin
            cnt_r[mecs_pkg::IDX_SQE] <= cnt_nxt[mecs_pkg::IDX_SQE];
        end
    end

    // Frames shorter than their length field
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r[mecs_pkg::IDX_LENGTH_MISMATCH_FIELD] <= '0;
        end else begin
            cnt_r[mecs_pkg::IDX_LENGTH_MISMATCH_FIELD] <= cnt_nxt[mecs_pkg::IDX_LENGTH_MISMATCH_FIELD];
        end
    end

    // Receive enable
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_en_r <= 1'b0;
        end else if (ctrl_wr) begin
            rx_en_r <= reg_wdata[mecs_pkg::CTRL_RX_EN_BIT];
        end
    end

    // Counter write enable
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stat_wr_en_r <= 1'b0;
        end else if (ctrl_wr) begin
            stat_wr_en_r <= reg_wdata[mecs_pkg::CTRL_STAT_WR_EN_BIT];
        end
    end

    // Long frame limit select
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            long_frame_r <= 1'b0;
        end else if (ctrl_wr) begin
            long_frame_r <= reg_wdata[mecs_pkg::CTRL_LONG_FRAME_BIT];
        end
    end

    // Full duplex mode
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            full_duplex_r <= 1'b0;
        end else if (ctrl_wr) begin
            full_duplex_r <= reg_wdata[mecs_pkg::CTRL_FULL_DUPLEX_BIT];
        end
    end

    // Length field check enable
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            len_check_r <= 1'b0;
        end else if (ctrl_wr) begin
            len_check_r <= reg_wdata[mecs_pkg::CTRL_LEN_CHECK_BIT];
        end
    end

    // Control word as software sees it; unused bits read zero
    always_comb begin
        ctrl_word                                 = '0;
        ctrl_word[mecs_pkg::CTRL_RX_EN_BIT]       = rx_en_r;
        ctrl_word[mecs_pkg::CTRL_STAT_WR_EN_BIT]  = stat_wr_en_r;
        ctrl_word[mecs_pkg::CTRL_LONG_FRAME_BIT]  = long_frame_r;
        ctrl_word[mecs_pkg::CTRL_FULL_DUPLEX_BIT] = full_duplex_r;
        ctrl_word[mecs_pkg::CTRL_LEN_CHECK_BIT]   = len_check_r;
    end

    // Read data mux
    always_comb begin
        rdata_nxt = '0;
        for (int i = 0; i < mecs_pkg::NUM_CNT; i++) begin
            if (rd_hit[i]) begin
                rdata_nxt = {16'h0000, cnt_r[i] & cnt_max(i)};
            end
        end
        if (reg_rd && reg_addr == mecs_pkg::OFS_CTRL) begin
            rdata_nxt = ctrl_word;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    assign ctrl_out = ctrl_word;

endmodule : mecs_counters

// [test/mecs_monitor.sv]
// Port assertions for the error statistics counters
module mecs_monitor (
    input wire logic                        core_clk,  // Clock
    input wire logic                        rst,       // Reset
    input wire logic [mecs_pkg::ADDR_W-1:0] reg_addr,  // Address
    input wire logic [mecs_pkg::DATA_W-1:0] reg_wdata, // Write data
    input wire logic                        reg_wr,    // Write strobe
    input wire logic                        reg_rd,    // Read strobe
    input wire logic [mecs_pkg::DATA_W-1:0] reg_rdata, // Read data
    input wire logic                        tx_done,   // Tx frame end
    input wire logic                        rx_done,   // Rx frame end
    input wire logic [mecs_pkg::DATA_W-1:0] ctrl_out   // Control
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    wire ctrl_wr = reg_wr && reg_addr == 8'h2c;
    sequence s_rd_clean;
        reg_rd && reg_addr <= 8'h28 && reg_addr[1:0] == 2'h0 && !tx_done && !rx_done;
    endsequence
    sequence s_rd_again;
        reg_rd && reg_addr == $past(reg_addr);
    endsequence
    property p_clear_on_read;
        s_rd_clean ##1 s_rd_again |=> reg_rdata == 32'h0;
    endproperty
    property p_idle_zero;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    property p_upper8;
        reg_rd && reg_addr != 8'h0c && reg_addr != 8'h2c |=> reg_rdata[31:8] == 24'h0;
    endproperty
    property p_upper16;
        reg_rd && reg_addr == 8'h0c |=> reg_rdata[31:16] == 16'h0;
    endproperty
    property p_unmapped;
        reg_rd && reg_addr > 8'h2c |=> reg_rdata == 32'h0;
    endproperty
    property p_ctrl_mask;
        (ctrl_out & ~mecs_pkg::CTRL_MASK) == 32'h0;
    endproperty
    property p_ctrl_wr;
        ctrl_wr |=> ctrl_out == ($past(reg_wdata) & mecs_pkg::CTRL_MASK);
    endproperty
    property p_ctrl_hold;
        !ctrl_wr |=> $stable(ctrl_out);
    endproperty
    property p_ctrl_read;
        reg_rd && reg_addr == 8'h2c |=> reg_rdata == $past(ctrl_out);
    endproperty
    a_clear_on_read: assert property (p_clear_on_read) else $error("Counter not cleared by read");
    a_idle_zero: assert property (p_idle_zero) else $error("Read data not zero when idle");
    a_upper8: assert property (p_upper8) else $error("Upper bits of 8-bit counter set");
    a_upper16: assert property (p_upper16) else $error("Upper bits of 16-bit counter set");
    a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero");
    a_ctrl_mask: assert property (p_ctrl_mask) else $error("Unused control bit set");
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("Control write lost");
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("Control changed without write");
    a_ctrl_read: assert property (p_ctrl_read) else $error("Control read mismatch");
endmodule : mecs_monitor

bind mecs_counters mecs_monitor mecs_monitor_inst (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_done(tx_done),
    .rx_done(rx_done), .ctrl_out(ctrl_out));

// [test/mecs_mac_model.sv]
// Behavioural transmit and receive engine side
module mecs_mac_model (
    input  wire logic              core_clk, // Clock
    output logic                   tx_done,  // Tx frame end
    output mecs_pkg::mecs_tx_evt_t tx_evt,   // Tx outcome
    output logic                   rx_done,  // Rx frame end
    output mecs_pkg::mecs_rx_evt_t rx_evt    // Rx outcome
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        tx_done = 1'b0;
        rx_done = 1'b0;
        tx_evt = '0;
        rx_evt = '0;
    end
    // One pulse per frame; outcome scrambled outside it
    task automatic tx(input mecs_pkg::mecs_tx_evt_t e);
        @(posedge core_clk);
        tx_evt  <= e;
        tx_done <= 1'b1;
        @(posedge core_clk);
        tx_evt  <= ~e;
        tx_done <= 1'b0;
    endtask : tx
    task automatic rx(input mecs_pkg::mecs_rx_evt_t e);
        @(posedge core_clk);
        rx_evt  <= e;
        rx_done <= 1'b1;
        @(posedge core_clk);
        rx_evt  <= ~e;
        rx_done <= 1'b0;
    endtask : rx
endmodule : mecs_mac_model

// [test/mecs_counters_test.sv]
// Self-checking bench for the error statistics counters
module mecs_counters_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic                   core_clk = 1'b0;
    logic                   rst = 1'b1;
    logic [7:0]             reg_addr = 8'h00;
    logic [31:0]            reg_wdata = 32'h0;
    logic                   reg_wr = 1'b0;
    logic                   reg_rd = 1'b0;
    logic [31:0]            reg_rdata;
    logic [31:0]            ctrl_out;
    logic                   tx_done;
    logic                   rx_done;
    mecs_pkg::mecs_tx_evt_t tx_evt;
    mecs_pkg::mecs_rx_evt_t rx_evt;
    int                     mismatches = 0;
    int                     compares = 0;
    int                     cycles = 0;
    always #25 core_clk = ~core_clk;
    mecs_counters mecs_counters_inst (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_done(tx_done), .tx_evt(tx_evt),
        .rx_done(rx_done), .rx_evt(rx_evt), .ctrl_out(ctrl_out));
    mecs_mac_model mecs_mac_model_inst (.core_clk(core_clk), .tx_done(tx_done), .tx_evt(tx_evt),
        .rx_done(rx_done), .rx_evt(rx_evt));
    task automatic stop_test();
        $display("Compares %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    // Counters flagged in m expect one, the rest zero
    task automatic rd_all(input logic [10:0] m);
        for (int i = 0; i < mecs_pkg::NUM_CNT; i++) begin
            rd(8'(i * 4), {31'h0, m[i]});
        end
    endtask : rd_all
    task automatic txf(input logic [4:0] f, input logic [10:0] m);
        mecs_mac_model_inst.tx(mecs_pkg::mecs_tx_evt_t'(f));
        rd_all(m);
    endtask : txf
    task automatic rxf(input logic [4:0] f, input logic [15:0] n, input logic [15:0] lt, input logic [10:0] m);
        mecs_mac_model_inst.rx(mecs_pkg::mecs_rx_evt_t'({f, n, lt}));
        rd_all(m);
    endtask : rxf
    task automatic t_reset();
        rd_all(11'h000);
        rd(8'h30, 32'h0);
        wr(8'h2c, 32'hffff_ffff);
        rd(8'h2c, mecs_pkg::CTRL_MASK);
    endtask : t_reset
    task automatic t_tx();
        wr(8'h2c, 32'h0);
        txf(5'h10, 11'h001);
        txf(5'h1f, 11'h002);
        txf(5'h04, 11'h004);
        txf(5'h06, 11'h000);
        txf(5'h01, 11'h200);
        txf(5'h05, 11'h204);
        wr(8'h2c, 32'h200);
        txf(5'h05, 11'h000);
    endtask : t_tx
    task automatic t_rx();
        wr(8'h2c, 32'h0);
        rxf(5'h10, 16'h0064, 16'h0000, 11'h000);
        wr(8'h2c, 32'h8);
        rxf(5'h10, 16'h0064, 16'h0000, 11'h008);
        rxf(5'h08, 16'h0064, 16'h0000, 11'h010);
        rxf(5'h04, 16'h0064, 16'h0000, 11'h020);
        rxf(5'h00, 16'h05ef, 16'h0000, 11'h040);
        rxf(5'h02, 16'h05ef, 16'h0000, 11'h080);
        rxf(5'h04, 16'h05ef, 16'h0000, 11'h0a0);
        rxf(5'h00, 16'h003f, 16'h0000, 11'h100);
        rxf(5'h01, 16'h003f, 16'h0000, 11'h000);
        rxf(5'h00, 16'h0040, 16'h0000, 11'h000);
        wr(8'h2c, 32'h108);
        rxf(5'h00, 16'h0600, 16'h0000, 11'h000);
        rxf(5'h00, 16'h0601, 16'h0000, 11'h040);
    endtask : t_rx
    task automatic t_len();
        wr(8'h2c, 32'h1_0008);
        rxf(5'h00, 16'h0064, 16'h00c8, 11'h400);
        rxf(5'h00, 16'h0064, 16'h0600, 11'h000);
        rxf(5'h00, 16'h0064, 16'h05ff, 11'h400);
        rxf(5'h00, 16'h05ef, 16'h05ff, 11'h040);
        wr(8'h2c, 32'h8);
        rxf(5'h00, 16'h0064, 16'h00c8, 11'h000);
    endtask : t_len
    task automatic t_wr();
        wr(8'h2c, 32'h0);
        wr(8'h00, 32'h55);
        rd(8'h00, 32'h0);
        wr(8'h2c, 32'h88);
        wr(8'h00, 32'hff);
        wr(8'h0c, 32'hffff);
        mecs_mac_model_inst.tx(mecs_pkg::mecs_tx_evt_t'(5'h10));
        mecs_mac_model_inst.rx(mecs_pkg::mecs_rx_evt_t'({5'h10, 16'h0064, 16'h0000}));
        rd(8'h0c, 32'hffff);
        @(posedge core_clk);
        reg_addr <= 8'h00;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        #1 chk(reg_rdata, 32'hff);
        @(posedge core_clk);
        #1 chk(reg_rdata, 32'h0);
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, 32'h0);
    endtask : t_wr
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_tx();
        t_rx();
        t_len();
        t_wr();
        stop_test();
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches++;
            stop_test();
        end
    end
endmodule : mecs_counters_test
